// ### dv/dac_sha_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_sha_defines.svh"
module dac_sha_ctrl_checker #(
   parameter int ACQ_CYCLES     = 20,
   parameter int ACQ_ALL_CYCLES = 40
) (
   input wire logic                             MCLK_I,
   input wire logic                             RST_N_I,
   input wire logic                             SCLK_I,
   input wire logic                             SYNC_N_I,
   input wire logic                             TRACK_RESET_N_I,
   input wire logic                             DOUT_OE_O,
   input wire logic                             BUSY_N_O,
   input wire logic [`NUM_CH-1:0][`CODE_W-1:0] CHANNEL_CODE_O,
   input wire logic [`NUM_CH-1:0]              TRACK_ROUTE_O,
   input wire logic                             OFFSET_TRACK_O
);
   int low_cnt_reg;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   // A restarted acquisition would overrun this count; tests avoid it
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) low_cnt_reg <= 0;
      else low_cnt_reg <= BUSY_N_O ? 0 : low_cnt_reg + 1;
   end
   reset_vals_a: assert property (
      $rose(RST_N_I) |-> BUSY_N_O && CHANNEL_CODE_O == '0)
      else $error("codes or busy not cleared by reset");
   busy_len_a: assert property (
      $rose(BUSY_N_O) |->
         low_cnt_reg == ACQ_CYCLES || low_cnt_reg == ACQ_ALL_CYCLES)
      else $error("acquisition length wrong");
   busy_track_a: assert property (
      $fell(BUSY_N_O) |-> TRACK_RESET_N_I)
      else $error("acquisition began while track low");
   busy_route_a: assert property (
      !BUSY_N_O |-> TRACK_ROUTE_O != '0 || OFFSET_TRACK_O)
      else $error("nothing routed during acquisition");
   route_end_a: assert property (
      $rose(BUSY_N_O) |-> TRACK_ROUTE_O == '0 && !OFFSET_TRACK_O)
      else $error("route kept after acquisition");
   code_quiet_a: assert property (
      $changed(CHANNEL_CODE_O) |->
         !SCLK_I || $rose(BUSY_N_O) || CHANNEL_CODE_O == '0)
      else $error("channel code changed without cause");
   oe_rise_a: assert property (
      $rose(DOUT_OE_O) |-> !SYNC_N_I && SCLK_I)
      else $error("readback drive began off a clock rise");
   oe_fall_a: assert property (
      $fell(DOUT_OE_O) |-> !SYNC_N_I && !SCLK_I)
      else $error("readback release off a clock fall");
   cover property ($fell(BUSY_N_O));
   cover property ($rose(DOUT_OE_O));
   cover property (CHANNEL_CODE_O == '0 && $past(CHANNEL_CODE_O) != '0);
   cover property (!BUSY_N_O && OFFSET_TRACK_O);
   cover property (!BUSY_N_O && TRACK_ROUTE_O == '1);
endmodule

bind dac_sha_ctrl dac_sha_ctrl_checker #(
   .ACQ_CYCLES(ACQ_CYCLES), .ACQ_ALL_CYCLES(ACQ_ALL_CYCLES)
) chk (
   .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .SCLK_I(SCLK_I),
   .SYNC_N_I(SYNC_N_I), .TRACK_RESET_N_I(TRACK_RESET_N_I),
   .DOUT_OE_O(DOUT_OE_O), .BUSY_N_O(BUSY_N_O),
   .CHANNEL_CODE_O(CHANNEL_CODE_O), .TRACK_ROUTE_O(TRACK_ROUTE_O),
   .OFFSET_TRACK_O(OFFSET_TRACK_O));
`default_nettype wire

// ### dv/dac_sha_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dac_sha_ctrl_tb_top;
   import dac_sha_pkg::*;
   typedef struct packed {
      logic [23:0] word;
      logic [5:0]  ch;
      logic [13:0] code;
   } row_s;
   // ch 3F marks a broadcast row, ch 20 the offset channel
   localparam row_s ROWS [6] = '{
      '{{MODE_DAC, 3'h4, 5'h00, 14'h2000}, 6'h3F, 14'h3FFF},
      '{{MODE_DAC, 3'h4, 5'h03, 14'h1FFF}, 6'h3F, 14'h0000},
      '{{MODE_DAC, 3'h0, 5'h00, 14'h0001}, 6'h00, 14'h0001},
      '{{MODE_DAC, 3'h0, 5'h1F, 14'h1555}, 6'h1F, 14'h1555},
      '{{MODE_DAC, 3'h2, 5'h07, 14'h1234}, 6'h20, 14'h1234},
      '{{MODE_DAC, 3'h1, 5'h09, 14'h0ABC}, 6'h09, 14'h0ABC}};
   logic              mclk = 1'b0, rst_n = 1'b0, track_n = 1'b1;
   logic              sclk, sync_n, din, dout, dout_oe, busy_n, offs_trk;
   logic [13:0]       adc = 14'h0000, offs, rd;
   logic [31:0][13:0] code;
   logic [31:0]       route;
   int                error_cnt = 0, n_tests = 0;
   dac_sha_ctrl #(.ACQ_CYCLES(20), .ACQ_ALL_CYCLES(40)) dut (
      .MCLK_I(mclk), .RST_N_I(rst_n), .SCLK_I(sclk), .SYNC_N_I(sync_n),
      .DIN_I(din), .TRACK_RESET_N_I(track_n), .ADC_CODE_I(adc),
      .DOUT_O(dout), .DOUT_OE_O(dout_oe), .BUSY_N_O(busy_n),
      .CHANNEL_CODE_O(code), .OFFSET_CODE_O(offs),
      .TRACK_ROUTE_O(route), .OFFSET_TRACK_O(offs_trk));
   serial_host host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din),
      .dout_i(dout_oe ? dout : ~dout)); // Released line reads as junk
   task automatic chk(input string nm, input logic [13:0] e,
                      input logic [13:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 100 && busy_n !== 1'b1; i++) @(negedge mclk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial forever #2.5 mclk = ~mclk;
   initial begin
      #200000;
      error_cnt++;
      $display("watchdog expired");
      test_done();
   end
   initial begin
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      repeat (5) @(negedge mclk);
      for (int r = 0; r < 6; r++) begin
         host.send_word(ROWS[r].word);
         #400;
         @(negedge mclk);
         if (ROWS[r].ch == 6'h3F) begin
            chk("bcast low", ROWS[r].code, code[0]);
            chk("bcast high", ROWS[r].code, code[31]);
         end else if (ROWS[r].ch == 6'h20) begin
            chk("offset", ROWS[r].code, offs);
            chk("addr ignored", 14'h0000, code[7]);
         end else begin
            chk("channel", ROWS[r].code, code[ROWS[r].ch[4:0]]);
         end
         $display("row %0d done", r);
      end
      adc = 14'h2B3C;
      host.send_head({MODE_SHA, 3'h0, 5'h03});
      @(negedge mclk);
      chk("busy", 14'h0000, {13'h0000, busy_n});
      chk("route", 14'h0001, {13'h0000, route[3]});
      wait_idle();
      chk("held", 14'h2B3C, code[3]);
      adc = 14'h0F0F;
      host.send_head({MODE_ACQ_RB, 3'h0, 5'h0C});
      wait_idle();
      #400;
      host.read(rd);
      chk("acq readback", 14'h0F0F, rd);
      #400;
      @(negedge mclk);
      host.send_head({MODE_RB, 3'h0, 5'h1F});
      #400;
      host.read(rd);
      chk("readback", 14'h1555, rd);
      @(negedge mclk);
      chk("released", 14'h0000, {13'h0000, dout_oe});
      $display("sample and readback tests done");
      track_n = 1'b0;
      adc = 14'h3C3C;
      repeat (40) @(negedge mclk);
      host.send_head({MODE_SHA, 3'h0, 5'h08});
      @(negedge mclk);
      chk("deferred", 14'h0001, {13'h0000, busy_n});
      chk("tracking", 14'h0001, {13'h0000, route[8]});
      track_n = 1'b1;
      repeat (8) @(negedge mclk);
      chk("late busy", 14'h0000, {13'h0000, busy_n});
      chk("no reset", 14'h0001, code[0]);
      wait_idle();
      chk("late code", 14'h3C3C, code[8]);
      chk("kept", 14'h2B3C, code[3]);
      track_n = 1'b0;
      repeat (5) @(negedge mclk);
      track_n = 1'b1;
      repeat (10) @(negedge mclk);
      chk("glitch", 14'h3C3C, code[8]);
      adc = 14'h1A2B;
      host.send_head({MODE_SHA, 3'h2, 5'h05});
      @(negedge mclk);
      chk("offs route", 14'h0001, {13'h0000, offs_trk});
      chk("offs no ch", 14'h0000, {13'h0000, route[5]});
      wait_idle();
      chk("offs acq", 14'h1A2B, offs);
      chk("offs route end", 14'h0000, {13'h0000, offs_trk});
      adc = 14'h2222;
      host.send_head({MODE_SHA, 3'h4, 5'h00});
      // Past a single-channel acquisition, still inside the broadcast one
      repeat (20) @(negedge mclk);
      chk("all busy", 14'h0000, {13'h0000, busy_n});
      wait_idle();
      chk("all low", 14'h2222, code[0]);
      chk("all high", 14'h2222, code[31]);
      chk("all offs", 14'h1A2B, offs);
      $display("offset and broadcast tests done");
      rst_n = 1'b0;
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      repeat (5) @(negedge mclk);
      chk("power-on offs", 14'h0000, offs);
      chk("power-on ch", 14'h0000, code[8]);
      host.send_word({MODE_DAC, 3'h0, 5'h09, 14'h0777});
      #400;
      @(negedge mclk);
      chk("rewrite", 14'h0777, code[9]);
      track_n = 1'b0;
      repeat (20) @(negedge mclk);
      track_n = 1'b1;
      repeat (10) @(negedge mclk);
      chk("soft reset", 14'h0000, code[9]);
      $display("reset tests done");
      test_done();
   end
endmodule
`default_nettype wire

// ### dv/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   output var logic sclk_o,
   output var logic sync_n_o,
   output var logic din_o,
   input  wire logic dout_i
);
   localparam realtime HALF = 62.5;
   // Clock parks high between frames; a released data line shows junk
   initial begin
      sclk_o = 1'b1;
      sync_n_o = 1'b1;
      din_o = 1'b1;
   end
   // Offset keeps link edges away from the system clock edges
   task automatic shift(input logic [23:0] w, input int n);
      #1.25 sync_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din_o = w[i];
         #HALF sclk_o = 1'b0;
         #HALF sclk_o = 1'b1;
      end
      sync_n_o = 1'b1;
      din_o = ~din_o;
   endtask
   task automatic send_word(input logic [23:0] w);
      shift(w, 24);
   endtask
   task automatic send_head(input logic [9:0] h);
      shift({14'h0000, h}, 10);
   endtask
   // First fall comes before any rise, so the device does not count it
   task automatic read(output logic [13:0] d);
      #1.25 sync_n_o = 1'b0;
      #HALF sclk_o = 1'b0;
      for (int i = 13; i >= 0; i--) begin
         #HALF sclk_o = 1'b1;
         din_o = ~din_o;
         #HALF d[i] = dout_i;
         sclk_o = 1'b0;
      end
      #HALF sclk_o = 1'b1;
      sync_n_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// ### hw/dac_sha_ctrl.sv

`timescale 1ns/1ps
`default_nettype none

module dac_sha_ctrl
   import dac_sha_pkg::*;
#(
   parameter int ACQ_CYCLES     = `ACQ_CYC,
   parameter int ACQ_ALL_CYCLES = `ACQ_ALL_CYC
) (
   input  wire logic                          MCLK_I,
   input  wire logic                          RST_N_I,
   input  wire logic                          SCLK_I,
   input  wire logic                          SYNC_N_I,
   input  wire logic                          DIN_I,
   input  wire logic                          TRACK_RESET_N_I,
   input  wire logic [`CODE_W-1:0]            ADC_CODE_I,
   output var  logic                          DOUT_O,
   output var  logic                          DOUT_OE_O,
   output var  logic                          BUSY_N_O,
   output var  logic [`NUM_CH-1:0][`CODE_W-1:0] CHANNEL_CODE_O,
   output var  logic [`CODE_W-1:0]            OFFSET_CODE_O,
   output var  logic [`NUM_CH-1:0]            TRACK_ROUTE_O,
   output var  logic                          OFFSET_TRACK_O
);

   ////////////////////////////////////////////////////////////////////////
   ctrl_s r_reg;
   ctrl_s r_next;

   logic sclk_fall;
   logic sclk_rise;
   logic sync_fall;
   logic trk_low;
   logic trk_rise;

   assign sclk_fall = r_reg.sclk_p[2] & ~r_reg.sclk_p[1];
   assign sclk_rise = ~r_reg.sclk_p[2] & r_reg.sclk_p[1];
   assign sync_fall = r_reg.sync_p[2] & ~r_reg.sync_p[1];
   assign trk_low   = ~r_reg.trk_p[1];
   assign trk_rise  = ~r_reg.trk_p[2] & r_reg.trk_p[1];

   ////////////////////////////////////////////////////////////////////////
   // Broadcast wins over offset select; it covers the 32 outputs only
   function automatic logic [`NUM_CH:0] target_mask(input cmd_s c);
      logic [`NUM_CH:0] m;
      m = '0;
      if (c.bcast) begin
         m[`NUM_CH-1:0] = '1;
      end else if (c.offs_sel) begin
         m[`OFFS_CH] = 1'b1;
      end else begin
         m[c.channel_address] = 1'b1;
      end
      return m;
   endfunction

   function automatic ctrl_s start_acq(input ctrl_s s);
      s.acq_run  = 1'b1;
      s.acq_pend = 1'b0;
      s.busy_n   = 1'b0;
      s.route    = s.tgt;
      if (&s.tgt[`NUM_CH-1:0]) begin
         s.acq_cnt = 14'(ACQ_ALL_CYCLES);
      end else begin
         s.acq_cnt = 14'(ACQ_CYCLES);
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      cmd_s             c;
      logic [`NUM_CH:0] m;
      logic [13:0]      code;
      c      = '0;
      m      = '0;
      code   = '0;
      r_next = r_reg;

      // Width of the track/reset low phase, saturating past the reset window
      if (trk_low) begin
         if (r_reg.low_cnt <= 6'(`RST_MAX_CYC)) begin
            r_next.low_cnt = r_reg.low_cnt + 6'h01;
         end
      end else begin
         r_next.low_cnt = '0;
      end

      // Long low: hold the last addressed channel in track, acquire on rise
      if (trk_low && r_reg.low_cnt > 6'(`RST_MAX_CYC)
          && !r_reg.acq_run && |r_reg.tgt) begin
         r_next.route    = r_reg.tgt;
         r_next.acq_pend = 1'b1;
      end

      // Acquisition timer; the converted code lands in the targets at the end
      if (r_reg.acq_run) begin
         if (r_reg.acq_cnt == 14'h0001) begin
            for (int i = 0; i <= `NUM_CH; i++) begin
               if (r_reg.tgt[i]) begin
                  r_next.codes[i] = ADC_CODE_I;
               end
            end
            r_next.route   = '0;
            r_next.busy_n  = 1'b1;
            r_next.acq_run = 1'b0;
         end else begin
            r_next.acq_cnt = r_reg.acq_cnt - 14'h0001;
         end
      end

      // A rise after a pulse longer than the reset window is a track release, not a reset
      if (trk_rise && r_reg.acq_pend
          && r_reg.low_cnt > 6'(`RST_MAX_CYC)) begin
         r_next = start_acq(r_next);
      end

      ////////////////////////////////////////////////////////////////////
      unique case (r_reg.phase)
         PH_IDLE: begin
            if (sync_fall) begin
               if (r_reg.rb_armed) begin
                  r_next.phase    = PH_READ;
                  r_next.rb_sh    = r_reg.codes[r_reg.rb_idx];
                  r_next.rb_cnt   = '0;
                  r_next.rb_armed = 1'b0;
               end else begin
                  r_next.phase   = PH_WRITE;
                  r_next.bit_cnt = '0;
               end
            end
         end
         PH_WRITE: begin
            // Frame select edges are not looked at until the word is done
            if (sclk_fall) begin
               r_next.sh      = {r_reg.sh[22:0], r_reg.din_p[1]};
               r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
               c = cmd_s'(r_next.sh[`SHA_BITS-1:0]);
               if (r_next.bit_cnt == 5'(`SHA_BITS)
                   && c.mode != MODE_DAC) begin
                  r_next.phase = PH_IDLE;
                  if (c.mode == MODE_SHA || c.mode == MODE_ACQ_RB) begin
                     r_next.tgt = target_mask(c);
                     if (r_reg.trk_p[1]) begin
                        r_next = start_acq(r_next);
                     end else begin
                        r_next.acq_pend = 1'b1;
                        r_next.acq_run  = 1'b0;
                        r_next.busy_n   = 1'b1;
                        r_next.route    = r_next.tgt;
                     end
                  end
                  if (c.mode != MODE_SHA) begin
                     r_next.rb_armed = 1'b1;
                     r_next.rb_idx   = c.offs_sel ? 6'(`OFFS_CH)
                                       : {1'b0, c.channel_address};
                  end
               end else if (r_next.bit_cnt == 5'(`DAC_BITS)) begin
                  c = cmd_s'(r_next.sh[`DAC_BITS-1:`CODE_W]);
                  m = target_mask(c);
                  if (c.bcast) begin
                     code = {`CODE_W{r_next.sh[`CODE_W-1]}};
                  end else begin
                     code = r_next.sh[`CODE_W-1:0];
                  end
                  for (int i = 0; i <= `NUM_CH; i++) begin
                     if (m[i]) begin
                        r_next.codes[i] = code;
                     end
                  end
                  r_next.phase = PH_IDLE;
               end
            end
         end
         PH_READ: begin
            // Input data is ignored for the whole read frame
            if (sclk_rise && r_reg.rb_cnt < 4'(`CODE_W)) begin
               r_next.dout    = r_reg.rb_sh[`CODE_W-1];
               r_next.dout_oe = 1'b1;
               r_next.rb_sh   = {r_reg.rb_sh[`CODE_W-2:0], 1'b0};
            end
            if (sclk_fall && r_reg.dout_oe) begin
               r_next.rb_cnt = r_reg.rb_cnt + 4'h1;
               if (r_reg.rb_cnt == 4'(`CODE_W - 1)) begin
                  r_next.dout_oe = 1'b0;
                  r_next.phase   = PH_IDLE;
               end
            end
         end
      endcase

      ////////////////////////////////////////////////////////////////////
      // Reset-width pulse: all state but the synchronisers back to power-on, shorter is ignored
      if (trk_rise && r_reg.low_cnt >= 6'(`RST_MIN_CYC)
          && r_reg.low_cnt <= 6'(`RST_MAX_CYC)) begin
         r_next        = '0;
         r_next.busy_n = 1'b1;
      end

      // Synchronisers run on regardless of the soft reset
      r_next.sclk_p = {r_reg.sclk_p[1:0], SCLK_I};
      r_next.sync_p = {r_reg.sync_p[1:0], SYNC_N_I};
      r_next.din_p  = {r_reg.din_p[0], DIN_I};
      r_next.trk_p  = {r_reg.trk_p[1:0], TRACK_RESET_N_I};
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         r_reg        <= '0;
         r_reg.busy_n <= 1'b1;
         r_reg.sync_p <= 3'h7;
         r_reg.trk_p  <= 3'h7;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign DOUT_O         = r_reg.dout;
   assign DOUT_OE_O      = r_reg.dout_oe;
   assign BUSY_N_O       = r_reg.busy_n;
   assign CHANNEL_CODE_O = r_reg.codes[`NUM_CH-1:0];
   assign OFFSET_CODE_O  = r_reg.codes[`OFFS_CH];
   assign TRACK_ROUTE_O  = r_reg.route[`NUM_CH-1:0];
   assign OFFSET_TRACK_O = r_reg.route[`OFFS_CH];

endmodule

`default_nettype wire

// ### hw/dac_sha_defines.svh
`ifndef DAC_SHA_DEFINES_SVH
`define DAC_SHA_DEFINES_SVH

`define MCLK_PERIOD_NS 5
`define RST_MIN_NS     50
`define RST_MAX_NS     150
`define RST_MIN_CYC    ((`RST_MIN_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define RST_MAX_CYC    (`RST_MAX_NS / `MCLK_PERIOD_NS)
`define ACQ_MAX_US     16
`define ACQ_CYC        ((`ACQ_MAX_US * 1000) / `MCLK_PERIOD_NS)
`define ACQ_ALL_US     45
`define ACQ_ALL_CYC    ((`ACQ_ALL_US * 1000) / `MCLK_PERIOD_NS)
`define CODE_W         14
`define NUM_CH         32
`define OFFS_CH        32
`define SHA_BITS       10
`define DAC_BITS       24

`endif

// ### hw/dac_sha_pkg.sv
`include "dac_sha_defines.svh"

package dac_sha_pkg;

   typedef enum logic [1:0] {
      MODE_SHA    = 2'h0,
      MODE_DAC    = 2'h1,
      MODE_ACQ_RB = 2'h2,
      MODE_RB     = 2'h3
   } mode_e;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_WRITE,
      PH_READ
   } phase_e;

   // Command head: first ten bits of every word, first bit on top
   typedef struct packed {
      mode_e      mode;
      logic       bcast;
      logic       offs_sel;
      logic       test;
      logic [4:0] channel_address;
   } cmd_s;

   typedef struct packed {
      logic [2:0]                      sclk_p;
      logic [2:0]                      sync_p;
      logic [1:0]                      din_p;
      logic [2:0]                      trk_p;
      phase_e                          phase;
      logic [4:0]                      bit_cnt;
      logic [23:0]                     sh;
      logic                            rb_armed;
      logic [5:0]                      rb_idx;
      logic [`CODE_W-1:0]              rb_sh;
      logic [3:0]                      rb_cnt;
      logic                            dout;
      logic                            dout_oe;
      logic [`NUM_CH:0][`CODE_W-1:0]   codes;
      logic [`NUM_CH:0]                tgt;
      logic [`NUM_CH:0]                route;
      logic                            acq_pend;
      logic                            acq_run;
      logic [13:0]                     acq_cnt;
      logic                            busy_n;
      logic [5:0]                      low_cnt;
   } ctrl_s;

endpackage
